// >>> hdl/sdf_pkg.sv
// constants, modes and helpers for the spi slave data formatter
package sdf_pkg;

  typedef enum logic [3:0] {
    BYTE_RAW_HI_FIRST,
    BYTE_RAW_LO_FIRST,
    HALF_WORD_HI_FIRST,
    HALF_WORD_LO_FIRST,
    WORD_HI_FIRST,
    WORD_LO_FIRST,
    HEXPAIR_TO_BYTE,
    HEXQUAD_HI_FIRST,
    HEXQUAD_LO_FIRST,
    HEXOCT_HI_FIRST,
    HEXOCT_LO_FIRST
  } sdf_mode_e;

  localparam logic [3:0] ADDR_ENCODE = 4'h0;
  localparam logic [3:0] ADDR_RXORDER = 4'h1;
  localparam logic [3:0] ADDR_TXORDER = 4'h2;
  localparam logic [3:0] ADDR_FILLER = 4'h3;
  localparam logic [3:0] ADDR_DUMMY = 4'h4;
  localparam logic [3:0] ADDR_RXSIZE = 4'h5;
  localparam logic [3:0] ADDR_TXDATA = 4'h6;
  localparam logic [3:0] ADDR_RXWORD = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_INTEN = 4'h9;
  localparam logic [3:0] ADDR_INTCLR = 4'hA;
  localparam logic [3:0] ADDR_RXCOUNT = 4'hB;

  localparam int ST_WORD = 0;
  localparam int ST_RXFULL = 1;
  localparam int ST_BADHEX = 2;
  localparam int ST_TXFULL = 8;

  localparam logic [3:0] ENCODE_RST = 4'h0;
  localparam logic [7:0] FILLER_RST = 8'hFF;
  localparam logic [7:0] DUMMY_RST = 8'h00;
  localparam logic [23:0] RXSIZE_RST = 24'h002000;

  // returns {valid, nibble} for one ASCII hex character
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
    begin
      r = {1'b1, c[3:0]};
    end
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
    begin
      r = {1'b1, 4'(c[3:0] + 4'h9)};
    end
    return r;
  endfunction

endpackage

// >>> hdl/sdf_byte_if.sv
// byte stream between the serial engine and the formatter
`timescale 1ns/1ps
interface sdf_byte_if;
  logic [7:0] rxByte;
  logic rxValid;
  logic [7:0] txByte;
  logic txTake;
  logic rxLsbFirst;
  logic txLsbFirst;
  modport engine (output rxByte, output rxValid, output txTake,
                  input txByte, input rxLsbFirst, input txLsbFirst);
  modport fmt (input rxByte, input rxValid, input txTake,
               output txByte, output rxLsbFirst, output txLsbFirst);
endinterface // sdf_byte_if

// >>> hdl/sdf_shifter.sv
// serial engine: spi mode 0 slave, one byte per eight serial clocks
`timescale 1ns/1ps
module sdf_shifter
  import sdf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  sdf_byte_if.engine bus
);

  logic sclkPrev_q;
  logic loaded_q, loaded_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxSh_q, rxSh_d;
  logic [7:0] txSh_q, txSh_d;
  logic [7:0] rxByte_q, rxByte_d;
  logic rxValid_q, rxValid_d;
  logic miso_q, miso_d;
  logic oe_q, oe_d;
  logic take;
  logic rise;
  logic fall;
  logic [7:0] rxNext;

  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  assign rise = sclk & ~sclkPrev_q;
  assign fall = ~sclk & sclkPrev_q;
  assign rxNext = bus.rxLsbFirst ? {mosi, rxSh_q[7:1]} : {rxSh_q[6:0], mosi};

  always_comb
  begin
    loaded_d = loaded_q;
    bitCnt_d = bitCnt_q;
    rxSh_d = rxSh_q;
    txSh_d = txSh_q;
    rxByte_d = rxByte_q;
    rxValid_d = 1'b0;
    miso_d = miso_q;
    oe_d = 1'b0;
    take = 1'b0;
    if (csN)
    begin
      loaded_d = 1'b0;
      bitCnt_d = 3'h0;
    end
    else
    begin
      oe_d = 1'b1;
      if (!loaded_q)
      begin
        txSh_d = bus.txByte;
        miso_d = out_bit(bus.txByte, bus.txLsbFirst);
        loaded_d = 1'b1;
        take = 1'b1;
      end
      else if (rise)
      begin
        rxSh_d = rxNext;
        bitCnt_d = 3'(bitCnt_q + 3'h1);
        if (bitCnt_q == 3'h7)
        begin
          rxByte_d = rxNext;
          rxValid_d = 1'b1;
          loaded_d = 1'b0;
        end
      end
      else if (fall && bitCnt_q != 3'h0)
      begin
        txSh_d = bus.txLsbFirst ? {1'b0, txSh_q[7:1]} : {txSh_q[6:0], 1'b0};
        miso_d = out_bit(txSh_d, bus.txLsbFirst);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sclkPrev_q <= 1'b0;
      loaded_q <= 1'b0;
      bitCnt_q <= 3'h0;
      rxSh_q <= 8'h00;
      txSh_q <= 8'h00;
      rxByte_q <= 8'h00;
      rxValid_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclk;
      loaded_q <= loaded_d;
      bitCnt_q <= bitCnt_d;
      rxSh_q <= rxSh_d;
      txSh_q <= txSh_d;
      rxByte_q <= rxByte_d;
      rxValid_q <= rxValid_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  assign miso = miso_q;
  assign misoOe = oe_q;
  assign bus.rxByte = rxByte_q;
  assign bus.rxValid = rxValid_q;
  assign bus.txTake = take;

  AST_OE_WHILE_SELECTED: assert property (@(posedge clk) disable iff (!nrst)
    !csN |=> misoOe)
    else $error("miso enable not following select");

  AST_BYTE_ON_EIGHTH: assert property (@(posedge clk) disable iff (!nrst)
    (!csN && loaded_q && rise && bitCnt_q == 3'h7) |=> rxValid_q && bitCnt_q == 3'h0)
    else $error("byte not completed on eighth clock");

endmodule // sdf_shifter

// >>> hdl/sdf_data_formatter.sv
// spi slave with register port, word packing, hex conversion and interrupt
`timescale 1ns/1ps
module sdf_data_formatter
  import sdf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  output logic irq
);

  sdf_byte_if bif ();

  logic [3:0] encode_q, encode_d;
  logic rxLsb_q, rxLsb_d;
  logic txLsb_q, txLsb_d;
  logic [7:0] filler_q, filler_d;
  logic [7:0] dummy_q, dummy_d;
  logic [23:0] rxSize_q, rxSize_d;
  logic [7:0] txData_q, txData_d;
  logic txFull_q, txFull_d;
  logic [2:0] intEn_q, intEn_d;
  logic [31:0] acc_q, acc_d;
  logic [3:0] cnt_q, cnt_d;
  logic [31:0] word_q, word_d;
  logic [23:0] rxCount_q, rxCount_d;
  logic [2:0] status_q, status_d;
  logic irq_q, irq_d;
  logic [31:0] rdData_q, rdData_d;
  logic [2:0] evt;
  logic [2:0] clr;
  logic take;
  logic wrEncode;
  logic isHex;
  logic hiFirst;
  logic [3:0] need;
  logic [4:0] nib;
  logic [4:0] sh;
  logic [31:0] accNext;
  sdf_mode_e mode;

  function automatic logic [31:0] place(input logic [31:0] a, input logic [7:0] v,
                                        input logic [4:0] s);
    return a | ({24'h000000, v} << s);
  endfunction

  sdf_shifter u_shift (
    .clk(clk),
    .nrst(nrst),
    .sclk(sclk),
    .csN(csN),
    .mosi(mosi),
    .miso(miso),
    .misoOe(misoOe),
    .bus(bif.engine)
  );

  assign bif.txByte = txFull_q ? txData_q : filler_q;
  assign bif.rxLsbFirst = rxLsb_q;
  assign bif.txLsbFirst = txLsb_q;

  // configuration, each setting its own register
  always_comb
  begin
    encode_d = encode_q;
    rxLsb_d = rxLsb_q;
    txLsb_d = txLsb_q;
    filler_d = filler_q;
    dummy_d = dummy_q;
    rxSize_d = rxSize_q;
    txData_d = txData_q;
    intEn_d = intEn_q;
    clr = 3'h0;
    txFull_d = txFull_q;
    if (bif.txTake)
    begin
      txFull_d = 1'b0;
    end
    if (wrEn)
    begin
      case (addr)
        ADDR_ENCODE: encode_d = wrData[3:0];
        ADDR_RXORDER: rxLsb_d = wrData[0];
        ADDR_TXORDER: txLsb_d = wrData[0];
        ADDR_FILLER: filler_d = wrData[7:0];
        ADDR_DUMMY: dummy_d = wrData[7:0];
        ADDR_RXSIZE: rxSize_d = wrData[23:0];
        ADDR_TXDATA:
        begin
          txData_d = wrData[7:0];
          txFull_d = 1'b1;
        end
        ADDR_INTEN: intEn_d = wrData[2:0];
        ADDR_INTCLR: clr = wrData[2:0];
        default: ;
      endcase
    end
  end

  assign wrEncode = wrEn && addr == ADDR_ENCODE;
  assign take = bif.rxValid && bif.rxByte != dummy_q;
  assign mode = sdf_mode_e'(encode_q);
  assign nib = hex_nib(bif.rxByte);

  always_comb
  begin
    isHex = 1'b0;
    hiFirst = 1'b1;
    need = 4'h1;
    case (mode)
      BYTE_RAW_HI_FIRST: need = 4'h1;
      BYTE_RAW_LO_FIRST: hiFirst = 1'b0;
      HALF_WORD_HI_FIRST: need = 4'h2;
      HALF_WORD_LO_FIRST:
      begin
        need = 4'h2;
        hiFirst = 1'b0;
      end
      WORD_HI_FIRST: need = 4'h4;
      WORD_LO_FIRST:
      begin
        need = 4'h4;
        hiFirst = 1'b0;
      end
      HEXPAIR_TO_BYTE:
      begin
        need = 4'h2;
        isHex = 1'b1;
      end
      HEXQUAD_HI_FIRST:
      begin
        need = 4'h4;
        isHex = 1'b1;
      end
      HEXQUAD_LO_FIRST:
      begin
        need = 4'h4;
        isHex = 1'b1;
        hiFirst = 1'b0;
      end
      HEXOCT_HI_FIRST:
      begin
        need = 4'h8;
        isHex = 1'b1;
      end
      HEXOCT_LO_FIRST:
      begin
        need = 4'h8;
        isHex = 1'b1;
        hiFirst = 1'b0;
      end
      default: need = 4'h1;
    endcase
  end

  // assembly of bytes or characters into words
  always_comb
  begin
    acc_d = acc_q;
    cnt_d = cnt_q;
    word_d = word_q;
    rxCount_d = rxCount_q;
    evt = 3'h0;
    sh = 5'h00;
    accNext = acc_q;
    if (isHex)
    begin
      // low-first hex fills byte lanes upward, high nibble of each pair first
      sh = {cnt_q[2:1], 3'b000} | (cnt_q[0] ? 5'h00 : 5'h04);
      accNext = hiFirst ? {acc_q[27:0], nib[3:0]} : place(acc_q, {4'h0, nib[3:0]}, sh);
    end
    else
    begin
      sh = {cnt_q[1:0], 3'b000};
      accNext = hiFirst ? {acc_q[23:0], bif.rxByte} : place(acc_q, bif.rxByte, sh);
    end
    if (wrEncode)
    begin
      // a new encoding restarts assembly rather than mixing units
      acc_d = 32'h00000000;
      cnt_d = 4'h0;
    end
    else if (take && isHex && !nib[4])
    begin
      evt[ST_BADHEX] = 1'b1;
    end
    else if (take)
    begin
      rxCount_d = 24'(rxCount_q + 24'h000001);
      if (rxCount_d == rxSize_q)
      begin
        evt[ST_RXFULL] = 1'b1;
        rxCount_d = 24'h000000;
      end
      if (4'(cnt_q + 4'h1) == need)
      begin
        word_d = accNext;
        acc_d = 32'h00000000;
        cnt_d = 4'h0;
        evt[ST_WORD] = 1'b1;
      end
      else
      begin
        acc_d = accNext;
        cnt_d = 4'(cnt_q + 4'h1);
      end
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_comb
  begin
    status_d = (status_q & ~clr) | evt;
    irq_d = |(status_d & intEn_d);
    rdData_d = 32'h00000000;
    if (rdEn)
    begin
      case (addr)
        ADDR_ENCODE: rdData_d = {28'h0000000, encode_q};
        ADDR_RXORDER: rdData_d = {31'h00000000, rxLsb_q};
        ADDR_TXORDER: rdData_d = {31'h00000000, txLsb_q};
        ADDR_FILLER: rdData_d = {24'h000000, filler_q};
        ADDR_DUMMY: rdData_d = {24'h000000, dummy_q};
        ADDR_RXSIZE: rdData_d = {8'h00, rxSize_q};
        ADDR_TXDATA: rdData_d = {24'h000000, txData_q};
        ADDR_RXWORD: rdData_d = word_q;
        ADDR_STATUS: rdData_d = {23'h000000, txFull_q, 5'h00, status_q};
        ADDR_INTEN: rdData_d = {29'h00000000, intEn_q};
        ADDR_RXCOUNT: rdData_d = {8'h00, rxCount_q};
        default: rdData_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      encode_q <= ENCODE_RST;
      rxLsb_q <= 1'b0;
      txLsb_q <= 1'b0;
      filler_q <= FILLER_RST;
      dummy_q <= DUMMY_RST;
      rxSize_q <= RXSIZE_RST;
      txData_q <= 8'h00;
      txFull_q <= 1'b0;
      intEn_q <= 3'h0;
      acc_q <= 32'h00000000;
      cnt_q <= 4'h0;
      word_q <= 32'h00000000;
      rxCount_q <= 24'h000000;
      status_q <= 3'h0;
      irq_q <= 1'b0;
      rdData_q <= 32'h00000000;
    end
    else
    begin
      encode_q <= encode_d;
      rxLsb_q <= rxLsb_d;
      txLsb_q <= txLsb_d;
      filler_q <= filler_d;
      dummy_q <= dummy_d;
      rxSize_q <= rxSize_d;
      txData_q <= txData_d;
      txFull_q <= txFull_d;
      intEn_q <= intEn_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      rxCount_q <= rxCount_d;
      status_q <= status_d;
      irq_q <= irq_d;
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_last_unit(sdf_mode_e m, logic [3:0] c);
    take && !wrEncode && mode == m && cnt_q == c;
  endsequence

  AST_DUMMY_DROPPED: assert property (
    (bif.rxValid && bif.rxByte == dummy_q) |=> rxCount_q == $past(rxCount_q))
    else $error("dummy byte was stored");
  AST_FILLER_WHEN_EMPTY: assert property (
    (bif.txTake && !txFull_q)
      |=> miso == ($past(txLsb_q) ? $past(filler_q[0]) : $past(filler_q[7])))
    else $error("empty buffer not sending filler");
  AST_HALF_HI: assert property (
    s_last_unit(HALF_WORD_HI_FIRST, 4'h1)
      |=> status_q[ST_WORD] && word_q == {$past(acc_q[23:0]), $past(bif.rxByte)})
    else $error("half word high first wrong");
  AST_HALF_LO: assert property (
    s_last_unit(HALF_WORD_LO_FIRST, 4'h1)
      |=> word_q[15:8] == $past(bif.rxByte) && word_q[7:0] == $past(acc_q[7:0]))
    else $error("half word low first wrong");
  AST_WORD_FOUR: assert property (
    s_last_unit(WORD_HI_FIRST, 4'h3) |=> status_q[ST_WORD] && cnt_q == 4'h0)
    else $error("word not completed after four bytes");
  AST_RAW_BYTE: assert property (
    s_last_unit(BYTE_RAW_HI_FIRST, 4'h0) |=> word_q[7:0] == $past(bif.rxByte))
    else $error("raw byte not passed");
  AST_HEXPAIR: assert property (
    (s_last_unit(HEXPAIR_TO_BYTE, 4'h1) and hex_nib(bif.rxByte) > 5'h0F)
      |=> word_q[7:0] == {$past(acc_q[3:0]), $past(nib[3:0])})
    else $error("hex pair converted wrongly");
  AST_HEXQUAD_LO: assert property (
    (s_last_unit(HEXQUAD_LO_FIRST, 4'h3) and nib[4])
      |=> word_q[15:8] == {$past(acc_q[15:12]), $past(nib[3:0])})
    else $error("swapped hex quad wrong");
  AST_HEXOCT_HI: assert property (
    (s_last_unit(HEXOCT_HI_FIRST, 4'h7) and nib[4])
      |=> word_q == {$past(acc_q[27:0]), $past(nib[3:0])})
    else $error("hex octet high first wrong");
  AST_ENCODE_ALONE: assert property (
    wrEncode |=> rxLsb_q == $past(rxLsb_q) && filler_q == $past(filler_q) && cnt_q == 4'h0)
    else $error("encode write disturbed other settings");
  AST_RXSIZE_EVENT: assert property (
    (take && !wrEncode && !(isHex && !nib[4]) && 24'(rxCount_q + 24'h000001) == rxSize_q)
      |=> status_q[ST_RXFULL] && rxCount_q == 24'h000000)
    else $error("buffer size event missing");

endmodule // sdf_data_formatter

// >>> tb/sdf_spi_master.sv
// behavioural spi mode 0 master driving the formatter's serial pins
`timescale 1ns/1ps
module sdf_spi_master (
  input wire logic clk,
  output logic sclk,
  output logic csN,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // master clocks reads with a byte of its choice
  // rate chosen here by the half period in clk cycles
  // a half of 100 gives a 1 MHz serial clock
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk);
    csN <= 1'b0;
    // gap after select so the first tx bit is on the line
    repeat (4) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      mosi <= tx[i];
      repeat (half) @(posedge clk);
      rx[i] = miso;
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge clk);
    csN <= 1'b1;
    // released data line shows the inverse so stale values never match
    mosi <= ~tx[0];
    repeat (4) @(posedge clk);
  endtask
endmodule // sdf_spi_master

// >>> tb/testbench.sv
// self-checking bench: register calls and serial bytes with expected values
`timescale 1ns/1ps
module testbench;
  import sdf_pkg::*;
  logic clk;
  logic nrst;
  logic [3:0] addr;
  logic [31:0] wrData;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdData;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  logic irq;
  logic [7:0] rxb;
  logic [31:0] rv;
  int mismatches;
  int checks;

  sdf_data_formatter DUT (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .sclk(sclk), .csN(csN),
    .mosi(mosi), .miso(miso), .misoOe(misoOe), .irq(irq));
  sdf_spi_master master (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    rv = rdData;
    chk(rv & m, e);
  endtask

  task automatic send(input logic [7:0] b);
    master.xfer(b, 4, rxb);
  endtask

  // first byte of s sits in the top lane; early is word-done after n-1 bytes
  task automatic run_mode(input sdf_mode_e m, input int n, input logic [63:0] s,
                          input logic early, input logic [31:0] e);
    wr(ADDR_ENCODE, 32'(m));
    wr(ADDR_INTCLR, 32'h00000007);
    for (int i = 0; i < n - 1; i++)
      send(s[63 - 8 * i -: 8]);
    rdchk(ADDR_STATUS, 32'h1, {31'h0, early});
    send(s[63 - 8 * (n - 1) -: 8]);
    rdchk(ADDR_STATUS, 32'h1, 32'h1);
    rdchk(ADDR_RXWORD, 32'hFFFFFFFF, e);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    nrst = 1'b0;
    addr = 4'h0;
    wrData = 32'h0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({30'h0, misoOe, irq}, 32'h0);
    rdchk(ADDR_ENCODE, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_FILLER, 32'hFFFFFFFF, 32'hFF);
    rdchk(ADDR_DUMMY, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_RXSIZE, 32'hFFFFFFFF, 32'h2000);
    rdchk(ADDR_RXORDER, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_TXORDER, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    wr(4'hC, 32'h12345678);
    rdchk(4'hC, 32'hFFFFFFFF, 32'h0);
    // byte count threshold, small so it is reached quickly
    wr(ADDR_RXSIZE, 32'h3);
    send(8'h11);
    send(8'h22);
    rdchk(ADDR_RXCOUNT, 32'hFFFFFFFF, 32'h2);
    rdchk(ADDR_STATUS, 32'h2, 32'h0);
    send(8'h33);
    rdchk(ADDR_STATUS, 32'h2, 32'h2);
    rdchk(ADDR_RXCOUNT, 32'hFFFFFFFF, 32'h0);
    wr(ADDR_RXSIZE, 32'h2000);
    // raw modes hand over each byte alone; the word holds the last one
    run_mode(BYTE_RAW_HI_FIRST, 4, 64'h1234567800000000, 1'b1, 32'h00000078);
    run_mode(BYTE_RAW_LO_FIRST, 4, 64'h1234567800000000, 1'b1, 32'h00000078);
    run_mode(HALF_WORD_HI_FIRST, 2, 64'h1234000000000000, 1'b0, 32'h00001234);
    run_mode(HALF_WORD_LO_FIRST, 2, 64'h1234000000000000, 1'b0, 32'h00003412);
    run_mode(WORD_HI_FIRST, 4, 64'h1234567800000000, 1'b0, 32'h12345678);
    run_mode(WORD_LO_FIRST, 4, 64'h1234567800000000, 1'b0, 32'h78563412);
    run_mode(HEXPAIR_TO_BYTE, 2, {"A8", 48'h0}, 1'b0, 32'h000000A8);
    run_mode(HEXQUAD_HI_FIRST, 4, {"ABCD", 32'h0}, 1'b0, 32'h0000ABCD);
    run_mode(HEXQUAD_LO_FIRST, 4, {"abcd", 32'h0}, 1'b0, 32'h0000CDAB);
    run_mode(HEXOCT_HI_FIRST, 8, "12345678", 1'b0, 32'h12345678);
    run_mode(HEXOCT_LO_FIRST, 8, "12345678", 1'b0, 32'h78563412);
    // dummy bytes in mid-word are dropped, not packed
    wr(ADDR_DUMMY, 32'h25);
    wr(ADDR_ENCODE, 32'(HALF_WORD_HI_FIRST));
    send(8'h11);
    send(8'h25);
    send(8'h22);
    rdchk(ADDR_RXWORD, 32'hFFFFFFFF, 32'h00001122);
    wr(ADDR_RXORDER, 32'h1);
    rdchk(ADDR_ENCODE, 32'hFFFFFFFF, 32'(HALF_WORD_HI_FIRST));
    rdchk(ADDR_DUMMY, 32'hFFFFFFFF, 32'h25);
    wr(ADDR_ENCODE, 32'(BYTE_RAW_HI_FIRST));
    send(8'h01);
    rdchk(ADDR_RXWORD, 32'hFFFFFFFF, 32'h80);
    wr(ADDR_RXORDER, 32'h0);
    // transmit side: filler while empty, stored byte once, then filler again
    master.xfer(8'h25, 4, rxb);
    chk({24'h0, rxb}, 32'hFF);
    wr(ADDR_FILLER, 32'hA5);
    master.xfer(8'h25, 4, rxb);
    chk({24'h0, rxb}, 32'hA5);
    wr(ADDR_TXDATA, 32'h3C);
    rdchk(ADDR_STATUS, 32'h100, 32'h100);
    master.xfer(8'h25, 4, rxb);
    chk({24'h0, rxb}, 32'h3C);
    rdchk(ADDR_STATUS, 32'h100, 32'h0);
    master.xfer(8'h25, 4, rxb);
    chk({24'h0, rxb}, 32'hA5);
    wr(ADDR_TXORDER, 32'h1);
    wr(ADDR_TXDATA, 32'h01);
    master.xfer(8'h25, 4, rxb);
    chk({24'h0, rxb}, 32'h80);
    wr(ADDR_TXORDER, 32'h0);
    // interrupt raised, masked and cleared
    wr(ADDR_INTCLR, 32'h7);
    wr(ADDR_INTEN, 32'h1);
    // let the edge that took the write settle before looking
    #1;
    chk({31'h0, irq}, 32'h0);
    send(8'h5A);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_INTEN, 32'h0);
    rdchk(ADDR_STATUS, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_INTEN, 32'h1);
    rdchk(ADDR_INTEN, 32'hFFFFFFFF, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_INTCLR, 32'h1);
    rdchk(ADDR_STATUS, 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // a non-hex character is refused and flagged
    wr(ADDR_ENCODE, 32'(HEXPAIR_TO_BYTE));
    send("G");
    rdchk(ADDR_STATUS, 32'h4, 32'h4);
    // one byte at the slow recommended rate, output enable seen before the first serial clock
    wr(ADDR_ENCODE, 32'(BYTE_RAW_HI_FIRST));
    fork
      master.xfer(8'h6B, 100, rxb);
      begin
        repeat (8) @(posedge clk);
        #1;
        chk({31'h0, misoOe}, 32'h1);
      end
    join
    rdchk(ADDR_RXWORD, 32'hFFFFFFFF, 32'h6B);
    end_of_test();
  end
endmodule // testbench
